// file: nvm_prog_consts.vh
/*
  constants for the parallel nonvolatile programming port: command codes,
  action-select codes, fuse and lock reset values, and the program timing.
  assumes it is included by bare name from the design file.
*/
`ifndef NVM_PROG_CONSTS_VH
`define NVM_PROG_CONSTS_VH

// ****************
// action select codes
// ****************
`define ACT_ADDR      2'h0
`define ACT_DATA      2'h1
`define ACT_CMD       2'h2
`define ACT_IDLE      2'h3

// ****************
// command bytes
// ****************
`define CMD_NOP       8'h00
`define CMD_ERASE     8'h80
`define CMD_WR_FUSE   8'h40
`define CMD_WR_LOCK   8'h20
`define CMD_WR_FLASH  8'h10
`define CMD_WR_EEP    8'h11
`define CMD_RD_ID     8'h08
`define CMD_RD_FUSE   8'h04
`define CMD_RD_FLASH  8'h02
`define CMD_RD_EEP    8'h03

// ****************
// reset values of nonvolatile cells (all erased)
// ****************
`define FUSE_LO_RST   8'hFF
`define FUSE_HI_RST   8'hFF
`define FUSE_EXT_RST  8'hFF
`define LOCK_RST      8'hFF
`define ERASED_BYTE   8'hFF

// ****************
// lock field positions: bits 1:0 memory protect, 5:2 boot protect
// ****************
`define LOCK_ONE_BIT  0
`define LOCK_TWO_BIT  1
`define BOOT_MASK     8'h3C

// ****************
// program time
// ****************
`define PROG_TIME_NS  1000
`define CLK_PERIOD_NS 10
`define PROG_CYCLES   (`PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

// file: nvm_prog_port.v
/*
  parallel programming port of a small nonvolatile store: command, address
  and data loading, flash/eeprom page buffers, fuses, lock bits, identity
  and calibration bytes, ready/busy.
  assumes all strobes are already synchronous to clk and each pulse lasts
  at least one clock; edges are found here on the sampled levels.
*/
// Functional notes
// - action 10 with load strobe loads command
// - command 0x10 writes flash via page buffer
// - action 00 loads address low or high
// - action 01 loads data low or high
// - page latch stores data at word address
// - low address bits word, upper bits page
// - write strobe programs page, busy until done
// - nop command clears internal write state
// - command 0x11 writes eeprom page, byte select low
// - flash read drives low/high byte per select
// - eeprom read drives addressed byte
// - fuse write picks low, high, extended byte
// - lock write programs zeros, boot guarded mode 3
// - lock bits set back to ones only by chip erase or reset
// - fuse/lock read selected by select pair
// - identity read returns byte at address 0..2
// - identity read high select returns calibration at address 0
// - ready_busy low while programming
// - action 11 is idle
// - command and address kept across operations
// - data bus driven only in the clock after one with output enable low
`timescale 1ns/1ps
`default_nettype none
`include "nvm_prog_consts.vh"

module nvm_prog_port #(
  parameter FLASH_AW    = 12,          // flash word address width
  parameter FPAGE_AW    = 5,           // flash words per page (log2)
  parameter EEP_AW      = 8,           // eeprom byte address width
  parameter EPAGE_AW    = 2,           // eeprom bytes per page (log2)
  parameter PROG_CYCLES = `PROG_CYCLES,
  parameter [7:0] ID0   = 8'h1E,       // identity bytes: values arbitrary
  parameter [7:0] ID1   = 8'h55,
  parameter [7:0] ID2   = 8'hAA,
  parameter [7:0] CAL   = 8'h80        // calibration byte: value arbitrary
)(
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // strobes and selects
  input  wire       load_strobe,
  input  wire       action_sel_hi,
  input  wire       action_sel_lo,
  input  wire       byte_sel_first,
  input  wire       byte_sel_second,
  input  wire       page_latch_strobe,
  input  wire       write_n,
  input  wire       out_en_n,
  // data bus, split into its three signals
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe,
  // status
  output reg        ready_busy
);

  // ****************
  // storage
  // ****************
  reg [15:0] flash_mem [0:(1<<FLASH_AW)-1];   // program words
  reg [7:0]  eep_mem   [0:(1<<EEP_AW)-1];     // data bytes
  reg [15:0] fpage_buf [0:(1<<FPAGE_AW)-1];   // flash page buffer
  reg [7:0]  epage_buf [0:(1<<EPAGE_AW)-1];   // eeprom page buffer
  reg [(1<<EPAGE_AW)-1:0] epage_vld_r;        // eeprom slots loaded

  // ****************
  // loaded state and strobe history
  // ****************
  reg [7:0]  cmd_r;           // current command
  reg [15:0] addr_r;          // high:low address
  reg [15:0] data_r;          // high:low data
  reg [7:0]  fuse_lo_r;
  reg [7:0]  fuse_hi_r;
  reg [7:0]  fuse_ext_r;
  reg [7:0]  lock_r;
  reg        load_d_r;        // previous strobe levels for edge finding
  reg        latch_d_r;
  reg        write_d_r;
  reg        page_dirty_r;    // internal write signal, cleared by nop
  reg [15:0] busy_cnt_r;
  reg [1:0]  op_r;            // pending operation while busy
  reg [FLASH_AW:0] erase_idx_r;

  localparam [1:0] OP_NONE  = 2'h0;
  localparam [1:0] OP_FLASH = 2'h1;
  localparam [1:0] OP_EEP   = 2'h2;
  localparam [1:0] OP_ERASE = 2'h3;

  // ****************
  // edges and decoded fields
  // ****************
  wire [1:0] act      = {action_sel_hi, action_sel_lo};
  wire       load_pe  = load_strobe & ~load_d_r;
  wire       latch_pe = page_latch_strobe & ~latch_d_r;
  wire       write_ne = ~write_n & write_d_r;
  wire       ready    = (busy_cnt_r == 16'h0000) & (op_r == OP_NONE);
  // low bits pick the word, the rest pick the page
  wire [FPAGE_AW-1:0] fword = addr_r[FPAGE_AW-1:0];
  wire [FLASH_AW-1:0] fword_addr = addr_r[FLASH_AW-1:0];
  wire [FLASH_AW-FPAGE_AW-1:0] fpage = addr_r[FLASH_AW-1:FPAGE_AW];
  wire [EPAGE_AW-1:0] eword = addr_r[EPAGE_AW-1:0];
  wire [EEP_AW-EPAGE_AW-1:0] epage = addr_r[EEP_AW-1:EPAGE_AW];
  wire       lock_mode3 = ~lock_r[`LOCK_ONE_BIT] & ~lock_r[`LOCK_TWO_BIT];
  wire [15:0] fword_rd = flash_mem[fword_addr];
  wire [7:0]  eep_rd   = eep_mem[addr_r[EEP_AW-1:0]];
  // a write strobe under any other code leaves ready_busy high
  wire        wr_listed = (cmd_r == `CMD_WR_FLASH) | (cmd_r == `CMD_WR_LOCK) |
                          (cmd_r == `CMD_WR_FUSE) | (cmd_r == `CMD_ERASE) |
                          ((cmd_r == `CMD_WR_EEP) & ~byte_sel_first);
  integer i;
  // ****************
  // command, address and data loading; latches; nonvolatile writes
  // ****************
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_r        <= 8'h00;
      addr_r       <= 16'h0000;
      data_r       <= 16'h0000;
      fuse_lo_r    <= `FUSE_LO_RST;
      fuse_hi_r    <= `FUSE_HI_RST;
      fuse_ext_r   <= `FUSE_EXT_RST;
      lock_r       <= `LOCK_RST;
      load_d_r     <= 1'b0;
      latch_d_r    <= 1'b0;
      write_d_r    <= 1'b1;
      page_dirty_r <= 1'b0;
      busy_cnt_r   <= 16'h0000;
      op_r         <= OP_NONE;
      erase_idx_r  <= {(FLASH_AW+1){1'b0}};
      epage_vld_r  <= {(1<<EPAGE_AW){1'b0}};
    end
    else
    begin
      load_d_r  <= load_strobe;
      latch_d_r <= page_latch_strobe;
      write_d_r <= write_n;
      // byte loads; strobes while busy are the programmer's fault
      if (load_pe && ready)
      begin
        if (act == `ACT_CMD)
        begin
          cmd_r <= data_in;
          if (data_in == `CMD_NOP)
          begin
            page_dirty_r <= 1'b0;
            epage_vld_r  <= {(1<<EPAGE_AW){1'b0}};
          end
        end
        else if (act == `ACT_ADDR)
        begin
          if (byte_sel_first)
            addr_r[15:8] <= data_in;
          else
            addr_r[7:0] <= data_in;
        end
        else if (act == `ACT_DATA)
        begin
          if (byte_sel_first)
            data_r[15:8] <= data_in;
          else
            data_r[7:0] <= data_in;
        end
        // act idle: nothing
      end
      // page latch fills a buffer word; command and address stay
      if (latch_pe && byte_sel_first && cmd_r == `CMD_WR_FLASH)
        page_dirty_r <= 1'b1;
      // write strobe starts an operation
      if (write_ne && ready)
      begin
        if (cmd_r == `CMD_WR_FLASH)
        begin
          op_r       <= OP_FLASH;
          busy_cnt_r <= PROG_CYCLES[15:0];
        end
        else if (cmd_r == `CMD_WR_EEP && !byte_sel_first)
        begin
          op_r       <= OP_EEP;
          busy_cnt_r <= PROG_CYCLES[15:0];
        end
        else if (cmd_r == `CMD_ERASE)
        begin
          op_r        <= OP_ERASE;
          busy_cnt_r  <= PROG_CYCLES[15:0];
          erase_idx_r <= {(FLASH_AW+1){1'b0}};
        end
        else if (cmd_r == `CMD_WR_FUSE)
        begin
          busy_cnt_r <= PROG_CYCLES[15:0];
          if (byte_sel_first && !byte_sel_second)
            fuse_hi_r <= data_r[7:0];
          else if (!byte_sel_first && byte_sel_second)
            fuse_ext_r <= data_r[7:0];
          else if (!byte_sel_first && !byte_sel_second)
            fuse_lo_r <= data_r[7:0];
        end
        else if (cmd_r == `CMD_WR_LOCK)
        begin
          busy_cnt_r <= PROG_CYCLES[15:0];
          // only programs (clears) bits; boot bits frozen in mode 3
          if (lock_mode3)
            lock_r <= lock_r & (data_r[7:0] | `BOOT_MASK);
          else
            lock_r <= lock_r & data_r[7:0];
        end
        // other codes: nothing changes
      end
      else if (busy_cnt_r != 16'h0000)
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      else if (op_r == OP_ERASE)
      begin
        // walk the arrays, then release lock bits last
        if (erase_idx_r[FLASH_AW])
        begin
          lock_r <= `LOCK_RST;
          op_r   <= OP_NONE;
        end
        else
          erase_idx_r <= erase_idx_r + {{FLASH_AW{1'b0}}, 1'b1};
      end
      else if (op_r != OP_NONE)
      begin
        op_r <= OP_NONE;
        if (op_r == OP_EEP)
          epage_vld_r <= {(1<<EPAGE_AW){1'b0}};
      end
      if (latch_pe && cmd_r == `CMD_WR_EEP)
        epage_vld_r[eword] <= 1'b1;
    end
  end

  // ****************
  // memory arrays: no reset, so they live in a plain clocked process
  // ****************
  always @(posedge clk)
  begin
    if (latch_pe && byte_sel_first && cmd_r == `CMD_WR_FLASH)
      fpage_buf[fword] <= data_r;
    if (latch_pe && cmd_r == `CMD_WR_EEP)
      epage_buf[eword] <= data_r[7:0];
    if (busy_cnt_r == 16'h0000 && op_r == OP_FLASH && page_dirty_r)
    begin
      for (i = 0; i < (1<<FPAGE_AW); i = i + 1)
        flash_mem[{fpage, i[FPAGE_AW-1:0]}] <= fpage_buf[i];
    end
    if (busy_cnt_r == 16'h0000 && op_r == OP_EEP)
    begin
      // only slots latched since the last page write or nop change
      for (i = 0; i < (1<<EPAGE_AW); i = i + 1)
        if (epage_vld_r[i])
          eep_mem[{epage, i[EPAGE_AW-1:0]}] <= epage_buf[i];
    end
    if (busy_cnt_r == 16'h0000 && op_r == OP_ERASE && !erase_idx_r[FLASH_AW])
    begin
      flash_mem[erase_idx_r[FLASH_AW-1:0]] <= {`ERASED_BYTE, `ERASED_BYTE};
      if (erase_idx_r[FLASH_AW-1:0] < (1<<EEP_AW))
        eep_mem[erase_idx_r[EEP_AW-1:0]] <= `ERASED_BYTE;
    end
  end

  // ****************
  // read mux and bus drive, registered onto the pins
  // ****************
  reg [7:0] rd_nxt;
  reg       oe_nxt;
  always @*
  begin
    rd_nxt = 8'h00;
    oe_nxt = 1'b0;
    if (!out_en_n)
    begin
      if (cmd_r == `CMD_RD_FLASH)
      begin
        oe_nxt = 1'b1;
        rd_nxt = byte_sel_first ? fword_rd[15:8] : fword_rd[7:0];
      end
      else if (cmd_r == `CMD_RD_EEP && !byte_sel_first)
      begin
        oe_nxt = 1'b1;
        rd_nxt = eep_rd;
      end
      else if (cmd_r == `CMD_RD_FUSE)
      begin
        oe_nxt = 1'b1;
        case ({byte_sel_second, byte_sel_first})
          2'b00:   rd_nxt = fuse_lo_r;
          2'b11:   rd_nxt = fuse_hi_r;
          2'b10:   rd_nxt = fuse_ext_r;
          default: rd_nxt = lock_r;
        endcase
      end
      else if (cmd_r == `CMD_RD_ID)
      begin
        oe_nxt = 1'b1;
        if (byte_sel_first)
          rd_nxt = (addr_r[7:0] == 8'h00) ? CAL : 8'h00;
        else if (addr_r[7:0] == 8'h00)
          rd_nxt = ID0;
        else if (addr_r[7:0] == 8'h01)
          rd_nxt = ID1;
        else if (addr_r[7:0] == 8'h02)
          rd_nxt = ID2;
      end
      // unlisted commands leave the bus released
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_out   <= 8'h00;
      data_oe    <= 1'b0;
      ready_busy <= 1'b1;
    end
    else
    begin
      data_out   <= rd_nxt;
      data_oe    <= oe_nxt;
      // low from the cycle after a write strobe until done
      ready_busy <= ready & ~(write_ne & wr_listed);
    end
  end
endmodule // nvm_prog_port
`default_nettype wire

// file: nvm_prog_monitor.sv
/*
  checker for the parallel programming port: relations on the top ports.
  assumes the bind below and a PROG_CYCLES equal to the instance's.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_prog_monitor #(
  parameter PROG_CYCLES = 4
)(
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // strobes and status
  input wire logic       write_n,
  input wire logic       out_en_n,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       ready_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ****************
  // busy length, counted since no repetition may span the program time
  // ****************
  reg [15:0] busy_r;  // cycles spent busy so far
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      busy_r <= 16'h0000;
    else
      busy_r <= ready_busy ? 16'h0000 : busy_r + 16'h0001;
  end
  // ****************
  // assertions
  // ****************
  a_oe_needs_enable: assert property (data_oe |-> !$past(out_en_n))
    else $error("bus driven without output enable");
  a_oe_drops_off: assert property (out_en_n |=> !data_oe)
    else $error("bus still driven after output enable released");
  a_bus_zero_idle: assert property (!data_oe |-> data_out == 8'h00)
    else $error("read data not cleared while bus released");
  a_busy_bounded: assert property (busy_r <= PROG_CYCLES + 2)
    else $error("busy lasted too long");
  a_busy_from_write: assert property ($fell(ready_busy) |->
    !$past(write_n) && ($past(write_n, 2) || $past(write_n, 3)))
    else $error("busy began without a write strobe");
  a_busy_min_len: assert property ($fell(ready_busy) |-> !ready_busy [*4])
    else $error("busy shorter than the program time");
  a_ready_out_reset: assert property ($rose(resetn) |-> ready_busy)
    else $error("not ready after reset");
  a_quiet_stays_ready: assert property (ready_busy && write_n &&
    $past(write_n) && $past(write_n, 2) |=> ready_busy)
    else $error("busy without any write strobe");
  // main scenarios reached
  c_write_started: cover property ($fell(ready_busy));
  c_write_done: cover property ($rose(ready_busy));
  c_bus_driven: cover property (data_oe);
endmodule // nvm_prog_monitor
bind nvm_prog_port nvm_prog_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
  .clk(clk), .resetn(resetn), .write_n(write_n), .out_en_n(out_en_n),
  .data_out(data_out), .data_oe(data_oe), .ready_busy(ready_busy));
`default_nettype wire

// file: nvm_programmer.sv
/*
  model of the external parallel programmer: strobes, selects, data bus.
  assumes one clock; every edge is held and spaced by at least one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_programmer (
  // clock and device status
  input wire logic       clk,
  input wire logic       ready_busy,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  // strobes and selects
  output logic           load_strobe,
  output logic     [1:0] act,
  output logic           byte_sel_first,
  output logic           byte_sel_second,
  output logic           page_latch_strobe,
  output logic           write_n,
  output logic           out_en_n,
  output logic     [7:0] data_in
);
  initial
  begin
    {load_strobe, act, byte_sel_first, byte_sel_second} = 5'h0C;
    {page_latch_strobe, write_n, out_en_n, data_in} = 11'h300;
  end
  // one byte load; never while busy, since the device ignores it then
  task automatic load(input [1:0] a, input bs, input [7:0] d);
    @(posedge clk);
    act <= a;
    byte_sel_first <= bs;
    data_in <= d;
    @(posedge clk) load_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    load_strobe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // latch the loaded word; byte select must be high
  task automatic latch();
    @(posedge clk) byte_sel_first <= 1'b1;
    @(posedge clk) page_latch_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    page_latch_strobe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // write pulse, then poll ready with a bound; selects back to low byte
  task automatic wr(input bs1, input bs2, output seen);
    integer i;
    seen = 1'b0;
    @(posedge clk);
    byte_sel_first <= bs1;
    byte_sel_second <= bs2;
    @(posedge clk) write_n <= 1'b0;
    // poll from the strobe on, so that even a one-cycle busy blip is seen
    for (i = 0; i < 200 && !(seen && ready_busy); i++)
    begin
      @(posedge clk);
      if (i == 2) write_n <= 1'b1;
      if (ready_busy === 1'b0) seen = 1'b1;
    end
    byte_sel_first <= 1'b0;
    byte_sel_second <= 1'b0;
  endtask
  // read with output enable low; the bus is released, so show new bits
  task automatic rd(input bs1, input bs2, output [7:0] v, output oe);
    @(posedge clk);
    byte_sel_first <= bs1;
    byte_sel_second <= bs2;
    out_en_n <= 1'b0;
    data_in <= ~data_in;
    repeat (3) @(posedge clk);
    #1 v = data_out;
    oe = data_oe;
    @(posedge clk) out_en_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule // nvm_programmer
`default_nettype wire

// file: nvm_prog_port_tb_top.sv
/*
  self-checking bench for the programming port with a programmer model.
  assumes the design's 1-cycle read latency and a short program time.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_prog_port_tb_top;
  localparam [7:0] ID0 = 8'h3C, ID1 = 8'h96, ID2 = 8'h0F;  // arbitrary
  localparam [7:0] CAL = 8'h71;                           // arbitrary
  reg        clk = 1'b0;
  reg        resetn = 1'b0;
  wire       ld, bs1, bs2, pl, wn, oen, oe, rb;
  wire [1:0] act;
  wire [7:0] din, dout;
  integer    err_total = 0, cmp_count = 0, cyc = 0, i;
  reg  [7:0] v, w;
  reg        d_oe, seen;
  always #5 clk = ~clk;
  nvm_prog_port #(.PROG_CYCLES(4), .ID0(ID0), .ID1(ID1), .ID2(ID2), .CAL(CAL)) u_dut (
    .clk(clk), .resetn(resetn), .load_strobe(ld), .action_sel_hi(act[1]),
    .action_sel_lo(act[0]), .byte_sel_first(bs1), .byte_sel_second(bs2),
    .page_latch_strobe(pl), .write_n(wn), .out_en_n(oen), .data_in(din),
    .data_out(dout), .data_oe(oe), .ready_busy(rb));
  nvm_programmer u_prog (
    .clk(clk), .ready_busy(rb), .data_out(dout), .data_oe(oe), .load_strobe(ld),
    .act(act), .byte_sel_first(bs1), .byte_sel_second(bs2), .page_latch_strobe(pl),
    .write_n(wn), .out_en_n(oen), .data_in(din));
  // ****************
  // comparison, verdict and hang guard
  // ****************
  task automatic chk(input string nm, input [7:0] seen_v, input [7:0] exp);
    cmp_count++;
    if (seen_v !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic cmd(input [7:0] c); u_prog.load(2'h2, 1'b0, c); endtask
  // ****************
  // scenarios
  // ****************
  // first and last word of a page, then nop and read back both bytes
  task automatic t_flash();
    cmd(8'h10);
    for (i = 0; i < 2; i++)
    begin
      w = i ? 8'h1F : 8'h00;
      u_prog.load(2'h0, 1'b0, w);
      u_prog.load(2'h1, 1'b0, w ^ 8'hA5);
      u_prog.load(2'h1, 1'b1, w ^ 8'h5A);
      u_prog.latch();
    end
    u_prog.load(2'h0, 1'b1, 8'h00);
    u_prog.wr(1'b0, 1'b0, seen);
    chk("flash busy", {7'h00, seen}, 8'h01);
    cmd(8'h00);
    cmd(8'h02);
    for (i = 0; i < 2; i++)
    begin
      w = i ? 8'h1F : 8'h00;
      u_prog.load(2'h0, 1'b0, w);
      u_prog.rd(1'b0, 1'b0, v, d_oe);
      chk("flash low", v, w ^ 8'hA5);
      u_prog.rd(1'b1, 1'b0, v, d_oe);
      chk("flash high", v, w ^ 8'h5A);
    end
  endtask
  task automatic t_eeprom();
    cmd(8'h11);
    u_prog.load(2'h0, 1'b1, 8'h00);
    u_prog.load(2'h0, 1'b0, 8'h05);
    u_prog.load(2'h1, 1'b0, 8'hC3);
    u_prog.latch();
    u_prog.wr(1'b0, 1'b0, seen);
    chk("eeprom busy", {7'h00, seen}, 8'h01);
    cmd(8'h03);
    u_prog.rd(1'b0, 1'b0, v, d_oe);
    chk("eeprom byte", v, 8'hC3);
    chk("eeprom drive", {7'h00, d_oe}, 8'h01);
  endtask
  // all three fuse bytes written, each read back by its select pair
  task automatic t_fuse();
    reg [7:0] fd [3];
    reg [2:0] wb1, wb2, rb1, rb2;
    fd = '{8'hE2, 8'hD9, 8'hFD};
    {wb1, wb2, rb1, rb2} = {3'b010, 3'b100, 3'b010, 3'b110};
    for (i = 0; i < 3; i++)
    begin
      cmd(8'h40);
      u_prog.load(2'h1, 1'b0, fd[i]);
      u_prog.wr(wb1[i], wb2[i], seen);
    end
    cmd(8'h04);
    for (i = 0; i < 3; i++)
    begin
      u_prog.rd(rb1[i], rb2[i], v, d_oe);
      chk("fuse byte", v, fd[i]);
    end
    u_prog.rd(1'b1, 1'b0, v, d_oe);
    chk("lock erased", v, 8'hFF);
  endtask
  // mode 3, then a boot-bit write and an attempted clear
  task automatic t_lock();
    cmd(8'h20);
    u_prog.load(2'h1, 1'b0, 8'hFC);
    u_prog.wr(1'b0, 1'b0, seen);
    u_prog.load(2'h1, 1'b0, 8'hC3);
    u_prog.wr(1'b0, 1'b0, seen);
    u_prog.load(2'h1, 1'b0, 8'hFF);
    u_prog.wr(1'b0, 1'b0, seen);
    cmd(8'h04);
    u_prog.rd(1'b1, 1'b0, v, d_oe);
    chk("lock bits", v, 8'hFC);
  endtask
  task automatic t_ident();
    cmd(8'h08);
    for (i = 0; i < 3; i++)
    begin
      u_prog.load(2'h0, 1'b0, i[7:0]);
      u_prog.rd(1'b0, 1'b0, v, d_oe);
      chk("identity", v, i == 0 ? ID0 : i == 1 ? ID1 : ID2);
    end
    u_prog.load(2'h0, 1'b0, 8'h00);
    u_prog.rd(1'b1, 1'b0, v, d_oe);
    chk("calibration", v, CAL);
  endtask
  // unlisted command; an idle-action load must not replace it
  task automatic t_other();
    cmd(8'h55);
    u_prog.wr(1'b0, 1'b0, seen);
    chk("odd busy", {7'h00, seen}, 8'h00);
    u_prog.load(2'h3, 1'b0, 8'h02);
    u_prog.rd(1'b0, 1'b0, v, d_oe);
    chk("odd drive", {7'h00, d_oe}, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_flash();
    t_eeprom();
    t_fuse();
    t_lock();
    t_ident();
    t_other();
    give_verdict();
  end
endmodule // nvm_prog_port_tb_top
`default_nettype wire
